// *** core/kwd_pkg.sv ***
package kwd_pkg;

   // ------------------------------------------------------------
   // Register map, byte addresses on the low address bits
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OMR_OFS = 8'h00;
   localparam logic [7:0] CMR_OFS = 8'h04;
   localparam logic [7:0] CR_OFS = 8'h08;
   localparam logic [7:0] SR_OFS = 8'h0C;
   localparam logic [7:0] EVS_OFS = 8'h10;
   localparam logic [7:0] EVM_OFS = 8'h14;

   // ------------------------------------------------------------
   // Overflow mode register fields
   // ------------------------------------------------------------
   localparam int OMR_EN_BIT = 0;
   localparam int OMR_RST_BIT = 1;
   localparam int OMR_IRQ_BIT = 2;
   localparam int OMR_PIN_BIT = 3;
   localparam int OMR_KEY_LO = 4;
   localparam int OMR_KEY_HI = 15;
   localparam logic [11:0] OMR_KEY = 12'h234;

   // ------------------------------------------------------------
   // Clock mode register fields
   // ------------------------------------------------------------
   localparam int CMR_CLKS_LO = 0;
   localparam int CMR_CLKS_HI = 1;
   localparam int CMR_HIGH_PRELOAD_VALUE_LO = 2;
   localparam int CMR_HIGH_PRELOAD_VALUE_HI = 5;
   localparam int CMR_KEY_LO = 7;
   localparam int CMR_KEY_HI = 15;
   localparam logic [8:0] CMR_KEY = 9'h06E;

   // ------------------------------------------------------------
   // Restart, counter and pin timing
   // ------------------------------------------------------------
   localparam logic [15:0] RESTART_KEY = 16'hC071;
   localparam logic [11:0] PRELOAD_LOW = 12'hFFF;
   localparam logic [3:0] PIN_LOW_CYCLES = 4'h8;
   localparam int SR_OVF_BIT = 0;

   // ------------------------------------------------------------
   // Prescaler: divide by 8, 32, 128, 1024 as count masks
   // ------------------------------------------------------------
   localparam int DIV_W = 10;
   localparam logic [9:0] DIV8_MASK = 10'h007;
   localparam logic [9:0] DIV32_MASK = 10'h01F;
   localparam logic [9:0] DIV128_MASK = 10'h07F;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;

   // ------------------------------------------------------------
   // Event status bits
   // ------------------------------------------------------------
   localparam int EV_W = 2;
   localparam int EV_OVF_BIT = 0;
   localparam int EV_KEY_BIT = 1;

   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } kwd_pre_state_t;

   localparam kwd_pre_state_t PRE_RST = '{default: '0};

   typedef struct packed {
      logic en;
      logic rst_en;
      logic irq_en;
      logic pin_en;
      logic [1:0] clks;
      logic [3:0] high_preload_value;
      logic [15:0] cnt;
      logic ovf_flag;
      logic [1:0] ev_stat;
      logic [1:0] ev_mask;
      logic [3:0] pin_cnt;
      logic pin_n;
      logic irq_pulse;
      logic reset_req;
      logic irq_line;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic readyout;
   } kwd_state_t;

   localparam kwd_state_t STATE_RST = '{
      cnt: {4'h0, PRELOAD_LOW},
      pin_n: 1'b1,
      readyout: 1'b1,
      default: '0
   };

endpackage

// *** core/kwd_tick_if.sv ***
`timescale 1ns/1ps
interface kwd_tick_if;
   logic [1:0] sel;
   logic tick;

   modport timer (output sel, input tick);
   modport pre (input sel, output tick);
endinterface

// *** core/kwd_prescaler.sv ***
`timescale 1ns/1ps
module kwd_prescaler (
   input wire logic hclk,   // Master clock
   input wire logic hresetn, // Async reset
   kwd_tick_if.pre tk        // Select in, tick out
);
   kwd_pkg::kwd_pre_state_t s_q;
   kwd_pkg::kwd_pre_state_t s_d;
   logic [9:0] mask;

   always_comb begin
      unique case (tk.sel)
         2'd0: mask = kwd_pkg::DIV8_MASK;
         2'd1: mask = kwd_pkg::DIV32_MASK;
         2'd2: mask = kwd_pkg::DIV128_MASK;
         2'd3: mask = kwd_pkg::DIV1024_MASK;
      endcase
   end

   // Free-running divider; one tick per selected period
   always_comb begin
      s_d = s_q;
      s_d.cnt = s_q.cnt + 10'h001;
      s_d.tick = ((s_q.cnt & mask) == mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= kwd_pkg::PRE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.tick = s_q.tick;
endmodule

// *** core/kwd_watchdog.sv ***
`timescale 1ns/1ps
module kwd_watchdog (
   input wire logic hclk,               // Master clock
   input wire logic hresetn,            // Async reset, active low
   input wire logic hsel,               // Slave select
   input wire logic [31:0] haddr,       // Byte address
   input wire logic [1:0] htrans,       // Transfer type
   input wire logic hwrite,             // Write when high
   input wire logic [2:0] hsize,        // Transfer size
   input wire logic hready,             // Bus ready in
   input wire logic [31:0] hwdata,      // Write data
   output logic [31:0] hrdata,          // Read data
   output logic hreadyout,              // Slave ready
   output logic hresp,                  // Always OKAY
   output logic overflow_irq,           // One-cycle overflow pulse
   output logic overflow_reset_req,     // One-cycle reset request
   output logic overflow_pin_n,         // Overflow pin, active low
   output logic irq                     // Level event interrupt
);
   kwd_pkg::kwd_state_t s_q;
   kwd_pkg::kwd_state_t s_d;
   kwd_tick_if tk ();

   logic addr_take;
   logic restart;
   logic overflow;
   logic [1:0] ev_set;
   logic [1:0] ev_clr;
   logic [31:0] rd_val;

   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   assign tk.sel = s_q.clks;

   kwd_prescaler u_pre (
      .hclk(hclk),
      .hresetn(hresetn),
      .tk(tk)
   );

   // ------------------------------------------------------------
   // Read mux, from current state
   // ------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (haddr[7:0])
         kwd_pkg::OMR_OFS: begin
            rd_val[kwd_pkg::OMR_EN_BIT] = s_q.en;
            rd_val[kwd_pkg::OMR_RST_BIT] = s_q.rst_en;
            rd_val[kwd_pkg::OMR_IRQ_BIT] = s_q.irq_en;
            rd_val[kwd_pkg::OMR_PIN_BIT] = s_q.pin_en;
            // Key field left at zero
         end
         kwd_pkg::CMR_OFS: begin
            rd_val[kwd_pkg::CMR_CLKS_HI:kwd_pkg::CMR_CLKS_LO] = s_q.clks;
            rd_val[kwd_pkg::CMR_HIGH_PRELOAD_VALUE_HI:kwd_pkg::CMR_HIGH_PRELOAD_VALUE_LO] = s_q.high_preload_value;
            // Key field left at zero
         end
         kwd_pkg::SR_OFS: begin
            rd_val[kwd_pkg::SR_OVF_BIT] = s_q.ovf_flag;
         end
         kwd_pkg::EVS_OFS: begin
            rd_val[kwd_pkg::EV_W-1:0] = s_q.ev_stat;
         end
         kwd_pkg::EVM_OFS: begin
            rd_val[kwd_pkg::EV_W-1:0] = s_q.ev_mask;
         end
         // Restart register is write-only; unmapped reads give zero
         default: rd_val = 32'h0000_0000;
      endcase
   end

   assign addr_take = hsel && htrans[1] && hready;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      restart = 1'b0;
      ev_set = 2'b00;
      ev_clr = 2'b00;
      overflow = 1'b0;
      s_d.irq_pulse = 1'b0;
      s_d.reset_req = 1'b0;

      // Data phase of a write; zero wait states
      if (s_q.dp_wr) begin
         unique case (s_q.dp_addr)
            kwd_pkg::OMR_OFS: begin
               if (hwdata[kwd_pkg::OMR_KEY_HI:kwd_pkg::OMR_KEY_LO] ==
                   kwd_pkg::OMR_KEY) begin
                  s_d.en = hwdata[kwd_pkg::OMR_EN_BIT];
                  s_d.rst_en = hwdata[kwd_pkg::OMR_RST_BIT];
                  s_d.irq_en = hwdata[kwd_pkg::OMR_IRQ_BIT];
                  s_d.pin_en = hwdata[kwd_pkg::OMR_PIN_BIT];
               end else begin
                  ev_set[kwd_pkg::EV_KEY_BIT] = 1'b1;
               end
            end
            kwd_pkg::CMR_OFS: begin
               if (hwdata[kwd_pkg::CMR_KEY_HI:kwd_pkg::CMR_KEY_LO] ==
                   kwd_pkg::CMR_KEY) begin
                  s_d.clks =
                     hwdata[kwd_pkg::CMR_CLKS_HI:kwd_pkg::CMR_CLKS_LO];
                  s_d.high_preload_value =
                     hwdata[kwd_pkg::CMR_HIGH_PRELOAD_VALUE_HI:kwd_pkg::CMR_HIGH_PRELOAD_VALUE_LO];
               end else begin
                  ev_set[kwd_pkg::EV_KEY_BIT] = 1'b1;
               end
            end
            kwd_pkg::CR_OFS: begin
               if (hwdata[15:0] == kwd_pkg::RESTART_KEY) begin
                  restart = 1'b1;
               end else begin
                  ev_set[kwd_pkg::EV_KEY_BIT] = 1'b1;
               end
            end
            kwd_pkg::EVS_OFS: begin
               ev_clr = hwdata[kwd_pkg::EV_W-1:0];
            end
            kwd_pkg::EVM_OFS: begin
               s_d.ev_mask = hwdata[kwd_pkg::EV_W-1:0];
            end
            // Status and unmapped writes are ignored
            default: s_d.ev_mask = s_q.ev_mask;
         endcase
      end

      // Counter; a restart outranks a tick in the same cycle
      if (restart) begin
         s_d.cnt = {s_q.high_preload_value, kwd_pkg::PRELOAD_LOW};
         s_d.ovf_flag = 1'b0;
      end else if (s_q.en && tk.tick) begin
         if (s_q.cnt == 16'h0000) begin
            overflow = 1'b1;
            s_d.cnt = {s_q.high_preload_value, kwd_pkg::PRELOAD_LOW};
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end

      // Overflow actions, only reachable while enabled
      if (overflow) begin
         s_d.ovf_flag = 1'b1;
         ev_set[kwd_pkg::EV_OVF_BIT] = 1'b1;
         s_d.reset_req = s_q.rst_en;
         s_d.irq_pulse = s_q.irq_en;
         if (s_q.pin_en) begin
            s_d.pin_cnt = kwd_pkg::PIN_LOW_CYCLES;
         end
      end

      // Pin low while the cycle count runs; a new overflow restarts it
      if (!(overflow && s_q.pin_en) && s_q.pin_cnt != 4'h0) begin
         s_d.pin_cnt = s_q.pin_cnt - 4'h1;
      end
      s_d.pin_n = (s_d.pin_cnt == 4'h0);

      // Sticky events; a set in the clearing cycle survives
      s_d.ev_stat = (s_q.ev_stat & ~ev_clr) | ev_set;
      s_d.irq_line = |(s_d.ev_stat & s_d.ev_mask);

      // Address phase capture
      if (addr_take) begin
         s_d.dp_wr = hwrite;
         s_d.dp_addr = haddr[7:0];
         s_d.rdata = hwrite ? 32'h0000_0000 : rd_val;
      end else begin
         s_d.dp_wr = 1'b0;
      end
      s_d.readyout = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= kwd_pkg::STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.readyout;
   assign hresp = 1'b0;
   assign overflow_irq = s_q.irq_pulse;
   assign overflow_reset_req = s_q.reset_req;
   assign overflow_pin_n = s_q.pin_n;
   assign irq = s_q.irq_line;
endmodule

// *** verif/kwd_watchdog_properties.sv ***
`timescale 1ns/1ps
module kwd_watchdog_properties (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size
   input wire logic hready, // Ready in
   input wire logic [31:0] hwdata, // Wdata
   input wire logic [31:0] hrdata, // Rdata
   input wire logic hreadyout, // Ready out
   input wire logic hresp, // Response
   input wire logic overflow_irq, // Irq pulse
   input wire logic overflow_reset_req, // Reset pulse
   input wire logic overflow_pin_n, // Pin
   input wire logic irq // Event irq
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence rd_at(logic [7:0] a);
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
   endsequence
   sequence pin_low8;
      !overflow_pin_n [*8];
   endsequence
   a_irq_single: assert property (overflow_irq |=> !overflow_irq [*8])
      else $error("irq pulse too long");
   a_rst_single: assert property (
      overflow_reset_req |=> !overflow_reset_req [*8])
      else $error("reset request too long");
   a_pin_eight: assert property (
      $fell(overflow_pin_n) |-> pin_low8 ##1 overflow_pin_n)
      else $error("pin low time wrong");
   a_omr_key_zero: assert property (
      rd_at(kwd_pkg::OMR_OFS) |=> hrdata[15:4] == 12'h000)
      else $error("mode key not zero");
   a_cmr_key_zero: assert property (
      rd_at(kwd_pkg::CMR_OFS) |=> hrdata[15:7] == 9'h000)
      else $error("clock key not zero");
   a_restart_reads_zero: assert property (
      rd_at(kwd_pkg::CR_OFS) |=> hrdata == 32'h0000_0000)
      else $error("restart read not zero");
   a_status_bits: assert property (
      rd_at(kwd_pkg::SR_OFS) |=> hrdata[31:1] == 31'h0000_0000)
      else $error("status spare bits set");
   a_resp_okay: assert property (hresp == 1'b0 && hreadyout)
      else $error("bus response wrong");
endmodule

bind kwd_watchdog kwd_watchdog_properties u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .overflow_irq(overflow_irq),
   .overflow_reset_req(overflow_reset_req),
   .overflow_pin_n(overflow_pin_n), .irq(irq));

// *** verif/kwd_sys_model.sv ***
`timescale 1ns/1ps
module kwd_sys_model (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset
   input wire logic overflow_irq, // Irq pulse in
   input wire logic overflow_reset_req, // Reset request in
   input wire logic overflow_pin_n, // Pin in
   output int irq_hits, // Irq pulses seen
   output int rst_hits, // Reset requests seen
   output int pin_len // Last low length
);
   int run;
   // Requests only recorded; a real reset would end the run
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_hits <= 0;
         rst_hits <= 0;
         pin_len <= 0;
         run <= 0;
      end else begin
         irq_hits <= irq_hits + int'(overflow_irq === 1'b1);
         rst_hits <= rst_hits + int'(overflow_reset_req === 1'b1);
         if (overflow_pin_n === 1'b0) begin
            run <= run + 1;
         end else if (run != 0) begin
            pin_len <= run;
            run <= 0;
         end
      end
   end
endmodule

// *** verif/tb_keyed_watchdog_timer.sv ***
`timescale 1ns/1ps
module tb_keyed_watchdog_timer;
   typedef struct {
      logic [7:0] wa;
      logic [31:0] wd;
      logic [7:0] ra;
      logic [31:0] exp;
   } kwd_row_t;
   localparam int SPAN = (int'(kwd_pkg::PRELOAD_LOW) + 1) * 8;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b000;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hready, hresp, ovf_irq, ovf_rst, ovf_pin_n, irq;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t0, irq_hits, rst_hits, pin_len;
   kwd_row_t rows [10];
   logic [7:0] rst_addr [5] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14};
   logic [7:0] ia [4] = '{8'h14, 8'h14, 8'h14, 8'h10};
   logic [31:0] id [4] = '{32'h2, 32'h0, 32'h2, 32'h2};
   logic ie [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   always #50 hclk = ~hclk;
   always @(posedge hclk) cyc <= cyc + 1;

   kwd_watchdog u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .overflow_irq(ovf_irq),
      .overflow_reset_req(ovf_rst), .overflow_pin_n(ovf_pin_n), .irq(irq));
   kwd_sys_model u_sys (.hclk(hclk), .hresetn(hresetn),
      .overflow_irq(ovf_irq), .overflow_reset_req(ovf_rst),
      .overflow_pin_n(ovf_pin_n), .irq_hits(irq_hits),
      .rst_hits(rst_hits), .pin_len(pin_len));

   task chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, rd, e);
   endtask
   task do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rst_addr[i]) rd_chk("reset", rst_addr[i], 32'h0);
      $display("test reset done");
   endtask
   task results;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge hclk);
      bad_count++;
      results();
   end

   initial begin
      rows = '{'{8'h04, 32'h373C, 8'h04, 32'h3C},
         '{8'h04, 32'h0001, 8'h04, 32'h3C}, '{8'h04, 32'h3701, 8'h04, 32'h1},
         '{8'h04, 32'h3700, 8'h04, 32'h0}, '{8'h00, 32'h2345, 8'h00, 32'h5},
         '{8'h00, 32'h1238, 8'h00, 32'h5}, '{8'h00, 32'h2340, 8'h00, 32'h0},
         '{8'h0C, 32'hFFFF, 8'h0C, 32'h0}, '{8'h08, 32'hC071, 8'h08, 32'h0},
         '{8'h3C, 32'hFFFF, 8'h3C, 32'h0}};
      do_reset();
      // Arming order as software is expected to use it
      bus(1'b1, kwd_pkg::OMR_OFS, 32'h0000_2340);
      bus(1'b1, kwd_pkg::CMR_OFS, 32'h0000_373C);
      bus(1'b1, kwd_pkg::CR_OFS, 32'h0000_C071);
      bus(1'b1, kwd_pkg::OMR_OFS, 32'h0000_2345);
      rd_chk("arm_mode", kwd_pkg::OMR_OFS, 32'h0000_0005);
      rd_chk("arm_clock", kwd_pkg::CMR_OFS, 32'h0000_003C);
      rd_chk("arm_flag", kwd_pkg::SR_OFS, 32'h0000_0000);
      $display("test arming done");
      foreach (rows[i]) begin
         bus(1'b1, rows[i].wa, rows[i].wd);
         rd_chk("row", rows[i].ra, rows[i].exp);
      end
      $display("test rows done");
      // Key errors above left event bit1 set
      foreach (ia[i]) begin
         bus(1'b1, ia[i], id[i]);
         repeat (2) @(posedge hclk);
         chk("irq", {31'h0, irq}, {31'h0, ie[i]});
      end
      $display("test interrupt done");
      bus(1'b1, kwd_pkg::CR_OFS, 32'h0000_C071);
      bus(1'b1, kwd_pkg::OMR_OFS, 32'h0000_234F);
      t0 = cyc;
      while (ovf_pin_n !== 1'b0 && cyc - t0 < 40000) @(posedge hclk);
      chk("span", 32'(cyc - t0 > SPAN - 16 && cyc - t0 < SPAN + 16), 1);
      repeat (12) @(posedge hclk);
      chk("irq_hits", 32'(irq_hits), 1);
      chk("rst_hits", 32'(rst_hits), 1);
      chk("pin_len", 32'(pin_len), 8);
      rd_chk("flag", kwd_pkg::SR_OFS, 32'h1);
      rd_chk("events", kwd_pkg::EVS_OFS, 32'h1);
      bus(1'b1, kwd_pkg::CR_OFS, 32'h0000_C070);
      rd_chk("bad_restart", kwd_pkg::SR_OFS, 32'h1);
      bus(1'b1, kwd_pkg::CR_OFS, 32'h0000_C071);
      rd_chk("restart", kwd_pkg::SR_OFS, 32'h0);
      $display("test overflow done");
      bus(1'b1, kwd_pkg::OMR_OFS, 32'h0000_234E);
      repeat (33000) @(posedge hclk);
      chk("off_hits", 32'(irq_hits + rst_hits + pin_len), 10);
      rd_chk("off_flag", kwd_pkg::SR_OFS, 32'h0);
      $display("test disabled done");
      do_reset();
      results();
   end
endmodule
